// >>> rtl/setpoint_alarm_output_control.sv
// setpoint output controller with APB register access
module setpoint_alarm_output_control #(
  parameter int unsigned TICK_CYCLES = setpoint_pkg::TICK_CYCLES
) (
  input logic pclk, // 50 MHz clock
  input logic presetn, // async reset, power up
  input logic [7:0] paddr, // apb byte address
  input logic psel, // apb select
  input logic penable, // apb access phase
  input logic pwrite, // apb direction
  input logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input logic card_fitted, // pin: output card present
  input logic rst_button, // pin: front reset button, high pressed
  input logic user_input, // pin: user input, high active
  input logic backlit_unit, // pin: backlight version strap
  input logic signed [17:0] display_value, // scaled display value
  input logic display_valid, // one-cycle pulse, new value
  input logic display_shown, // input display is on screen
  output logic [1:0] sp_out, // setpoint outputs to the card
  output logic backlight_red, // backlight colour, 1 red 0 green
  output logic irq // level interrupt
);
  localparam int N = setpoint_pkg::NSP;
  localparam int DW = setpoint_pkg::DLY_W;
  localparam logic [DW-1:0] DLY_MAX_C = setpoint_pkg::DLY_MAX; // sat count

  // every engine assertion runs on pclk and sleeps during power up
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  setpoint_pkg::apb_req_s req; // bundled apb request
  assign req = '{addr: paddr, sel: psel, enable: penable,
                 write: pwrite, wdata: pwdata};

  // ---------------- pin synchronisers ----------------
  logic [3:0] pin_s1; // first stage, read only by pin_s2
  logic [3:0] pin_s2; // stable pin levels
  logic [1:0] pin_s3; // delayed levels for edge detect
  logic card_ok; // card present
  logic backlit_ok; // backlight version
  logic btn_edge; // button press event
  logic usr_edge; // user input activation event

  // two flops on every pin, third stage only for press edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      pin_s3 <= 2'h0;
    end else begin
      pin_s1 <= {backlit_unit, user_input, rst_button, card_fitted};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2[2:1];
    end
  end
  assign card_ok = pin_s2[0];
  assign backlit_ok = pin_s2[3];
  assign btn_edge = pin_s2[1] & ~pin_s3[0]; // momentary, edge acting
  assign usr_edge = pin_s2[2] & ~pin_s3[1];

  // ---------------- 0.1 s tick divider ----------------
  logic [31:0] div_cnt; // cycles within a tick
  logic tick; // one-cycle pulse every tenth second

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 32'h0;
    end else if (tick) begin
      div_cnt <= 32'h0;
    end else begin
      div_cnt <= div_cnt + 32'h1;
    end
  end
  assign tick = (div_cnt == 32'(TICK_CYCLES - 1));

  // ---------------- register decode ----------------
  // true when the address hits a register
  function automatic logic mapped(input logic [7:0] a);
    logic f;
    f = 1'b0;
    if (a == setpoint_pkg::OFF_SRC || a == setpoint_pkg::OFF_CMD ||
        a == setpoint_pkg::OFF_STATUS ||
        a == setpoint_pkg::OFF_IRQ_STAT ||
        a == setpoint_pkg::OFF_IRQ_MASK) begin
      f = 1'b1;
    end else if (a >= setpoint_pkg::OFF_SP_BASE &&
                 a < setpoint_pkg::OFF_SP_END) begin
      f = (a[4:0] <= setpoint_pkg::SPF_OFF) && (a[1:0] == 2'b00);
    end
    return f;
  endfunction

  // setpoint block hit by the address, and which setpoint
  function automatic logic sp_hit(input logic [7:0] a, input int idx);
    return (a >= setpoint_pkg::OFF_SP_BASE) &&
           (a < setpoint_pkg::OFF_SP_END) && (a[6] == idx[0]);
  endfunction

  // clamp an unsigned field into a range
  function automatic logic [15:0] clamp16(input logic [15:0] v,
      input logic [15:0] lo, input logic [15:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  logic wr_acc; // write access phase, slave always ready
  logic rd_setup; // read setup phase, data fetched early
  assign wr_acc = req.sel & req.enable & req.write & mapped(req.addr);
  assign rd_setup = req.sel & ~req.enable & ~req.write;
  assign pready = 1'b1; // zero wait states
  assign pslverr = req.sel & req.enable & ~mapped(req.addr);

  // ---------------- software registers ----------------
  logic [5:0] src_cfg; // reset source routing
  setpoint_pkg::sp_cfg_s cfg [N]; // per setpoint configuration
  logic signed [17:0] thr [N]; // thresholds
  logic [15:0] hys [N]; // hysteresis amounts
  logic [DW-1:0] on_dly [N]; // on delays, tenths of a second
  logic [DW-1:0] off_dly [N]; // off delays
  logic [1:0] irq_stat; // sticky output change events
  logic [1:0] irq_mask; // interrupt enables
  logic [1:0] cmd_rst; // serial reset command pulse
  logic signed [17:0] wthr; // threshold being written, clamped
  logic signed [31:0] wfull; // whole write word as a signed value

  // clamp on the full word so large values cannot wrap negative
  always_comb begin
    wfull = signed'(req.wdata);
    wthr = wfull[17:0];
    if (wfull > 32'(setpoint_pkg::THR_MAX)) begin
      wthr = setpoint_pkg::THR_MAX;
    end else if (wfull < 32'(setpoint_pkg::THR_MIN)) begin
      wthr = setpoint_pkg::THR_MIN;
    end
  end

  // configuration writes; out of range values are clamped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_cfg <= setpoint_pkg::SRC_RST;
      irq_mask <= 2'h0;
      for (int i = 0; i < N; i++) begin
        cfg[i] <= setpoint_pkg::CFG_RST;
        thr[i] <= 18'h00000;
        hys[i] <= setpoint_pkg::HYS_RST;
        on_dly[i] <= 16'h0000;
        off_dly[i] <= 16'h0000;
      end
    end else if (wr_acc) begin
      if (req.addr == setpoint_pkg::OFF_SRC) begin
        src_cfg <= req.wdata[5:0];
      end
      if (req.addr == setpoint_pkg::OFF_IRQ_MASK) begin
        irq_mask <= req.wdata[1:0];
      end
      for (int i = 0; i < N; i++) begin
        if (sp_hit(req.addr, i)) begin
          case (req.addr[4:0])
            setpoint_pkg::SPF_CFG: cfg[i] <= req.wdata[7:0];
            setpoint_pkg::SPF_THR: thr[i] <= wthr;
            setpoint_pkg::SPF_HYS: begin
              hys[i] <= clamp16(req.wdata[15:0], setpoint_pkg::HYS_MIN,
                                setpoint_pkg::HYS_MAX);
            end
            setpoint_pkg::SPF_ON: begin
              on_dly[i] <= clamp16(req.wdata[15:0], 16'h0000,
                                   setpoint_pkg::DLY_MAX);
            end
            setpoint_pkg::SPF_OFF: begin
              off_dly[i] <= clamp16(req.wdata[15:0], 16'h0000,
                                    setpoint_pkg::DLY_MAX);
            end
            default: ;
          endcase
        end
      end
    end
  end

  // serial reset command: one-cycle pulse per written one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_rst <= 2'h0;
    end else if (wr_acc && req.addr == setpoint_pkg::OFF_CMD) begin
      cmd_rst <= req.wdata[1:0];
    end else begin
      cmd_rst <= 2'h0;
    end
  end

  // ---------------- manual reset routing ----------------
  logic disp_rst; // display reset with input display shown
  logic [1:0] rst_req; // manual reset per setpoint
  assign disp_rst = display_shown &
      ((btn_edge & src_cfg[setpoint_pkg::SRC_BTN_DISP]) |
       (usr_edge & src_cfg[setpoint_pkg::SRC_USR_DISP]));
  always_comb begin
    for (int i = 0; i < N; i++) begin
      rst_req[i] = (btn_edge & src_cfg[setpoint_pkg::SRC_BTN_MASK + i]) |
                   (usr_edge & src_cfg[setpoint_pkg::SRC_USR_MASK + i]) |
                   cmd_rst[i] | (disp_rst & cfg[i].disp_reset);
    end
  end

  // ---------------- setpoint engines ----------------
  logic [1:0] out_q; // output states
  logic [1:0] chg; // output changes this cycle
  logic [1:0] pend_q; // deferred resets waiting
  logic [1:0] hold_q; // standby holds

  for (genvar i = 0; i < N; i++) begin : g_sp
    logic signed [19:0] v; // display value, widened
    logic signed [19:0] t; // threshold, widened
    logic signed [19:0] h; // full hysteresis
    logic signed [19:0] half; // half hysteresis for balanced
    logic signed [19:0] on_lvl; // switch on point
    logic signed [19:0] off_lvl; // switch off point
    logic hi; // high acting
    logic unb; // unbalanced band
    logic cond_on; // last update at or past on point
    logic cond_off; // last update at or past off point
    logic active; // card fitted and setpoint enabled
    logic latched; // latching reset mode
    logic goal; // transition wanted
    logic [DW-1:0] dly; // delay for the wanted transition
    logic [DW-1:0] cnt; // delay ticks elapsed
    logic blocked; // manual reset until next crossing
    logic next_out, next_blocked, next_pend, next_hold;
    logic [DW-1:0] next_cnt;

    assign v = 20'(display_value);
    assign t = 20'(thr[i]);
    assign h = signed'({4'h0, hys[i]});
    assign half = signed'({5'h00, hys[i][15:1]});
    assign hi = (cfg[i].action == setpoint_pkg::ACT_HI_BAL) ||
                (cfg[i].action == setpoint_pkg::ACT_HI_UNB);
    assign unb = (cfg[i].action == setpoint_pkg::ACT_HI_UNB) ||
                 (cfg[i].action == setpoint_pkg::ACT_LO_UNB);
    // unbalanced band sits wholly on the off side of the threshold
    assign on_lvl = unb ? t : (hi ? t + half : t - half);
    assign off_lvl = hi ? (unb ? t - h : t - half)
                        : (unb ? t + h : t + half);
    assign active = card_ok & cfg[i].enable;
    assign latched = cfg[i].rmode != setpoint_pkg::RST_AUTO;

    // comparisons sampled once per display update
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cond_on <= 1'b0;
        cond_off <= 1'b0;
      end else if (display_valid) begin
        cond_on <= hi ? (v >= on_lvl) : (v <= on_lvl);
        cond_off <= hi ? (v <= off_lvl) : (v >= off_lvl);
      end
    end

    // next state: delays, latching, manual reset, standby
    always_comb begin
      next_out = out_q[i];
      next_cnt = cnt;
      next_blocked = blocked;
      next_pend = pend_q[i];
      next_hold = hold_q[i];
      goal = 1'b0;
      dly = on_dly[i];
      if (!active) begin
        next_out = 1'b0;
        next_cnt = '0;
        next_blocked = 1'b0;
        next_pend = 1'b0;
      end else begin
        if (cond_off) begin
          next_blocked = 1'b0; // crossing back re-arms
          next_hold = 1'b0;
        end
        if (!out_q[i]) begin
          goal = cond_on & ~blocked & ~(cfg[i].standby & hold_q[i]);
          dly = on_dly[i];
        end else if (latched) begin
          // latch holds; only a deferred reset ends it here
          goal = (cfg[i].rmode == setpoint_pkg::RST_LATCH_DEFERRED_CLEAR)
                 & pend_q[i] & cond_off;
          dly = off_dly[i];
        end else begin
          goal = cond_off;
          dly = off_dly[i];
        end
        if (goal) begin
          if (cnt >= dly) begin
            next_out = ~out_q[i];
            next_cnt = '0;
            next_pend = 1'b0;
            next_hold = 1'b0;
          end else if (tick && cnt != DLY_MAX_C) begin
            next_cnt = cnt + 16'h0001;
          end
        end else begin
          next_cnt = '0; // condition lost, restart delay
        end
        if (rst_req[i]) begin
          if (cfg[i].rmode == setpoint_pkg::RST_LATCH_DEFERRED_CLEAR) begin
            next_pend = out_q[i];
            next_out = out_q[i];
          end else begin
            next_out = 1'b0;
            next_blocked = 1'b1;
            next_cnt = '0;
          end
        end
      end
    end

    // power up clears outputs and discards pending resets
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        out_q[i] <= 1'b0;
        pend_q[i] <= 1'b0;
        hold_q[i] <= 1'b1;
        cnt <= '0;
        blocked <= 1'b0;
      end else begin
        out_q[i] <= next_out;
        pend_q[i] <= next_pend;
        hold_q[i] <= next_hold;
        cnt <= next_cnt;
        blocked <= next_blocked;
      end
    end
    assign chg[i] = next_out != out_q[i];

    no_card_a: assert property (!card_ok |=> !out_q[i])
      else $error("output on without card");
    sp_off_a: assert property (!cfg[i].enable |=> !out_q[i])
      else $error("disabled setpoint output on");
    on_delay_a: assert property ($rose(out_q[i]) |->
        $past(cnt) >= $past(on_dly[i]))
      else $error("output on before on delay");
    off_delay_a: assert property ($fell(out_q[i]) && !$past(rst_req[i])
        |-> $past(cnt) >= $past(off_dly[i]))
      else $error("output off before off delay");
    manual_clear_a: assert property (active && rst_req[i] &&
        cfg[i].rmode != setpoint_pkg::RST_LATCH_DEFERRED_CLEAR
        |=> !out_q[i])
      else $error("manual reset left output on");
    latch_hold_a: assert property (active && out_q[i] &&
        cfg[i].rmode == setpoint_pkg::RST_LATCH_NOW && !rst_req[i]
        |=> out_q[i])
      else $error("latched output dropped");
    defer_hold_a: assert property (active && out_q[i] &&
        cfg[i].rmode == setpoint_pkg::RST_LATCH_DEFERRED_CLEAR &&
        !(pend_q[i] && cond_off) |=> out_q[i])
      else $error("deferred latch dropped early");
    standby_a: assert property ($rose(out_q[i]) |->
        !($past(cfg[i].standby) && $past(hold_q[i])))
      else $error("output on during standby");
  end

  assign sp_out = out_q;

  // ---------------- events and backlight ----------------
  logic irq_clr_wr; // software clearing sticky bits
  assign irq_clr_wr = wr_acc && req.addr == setpoint_pkg::OFF_IRQ_STAT;

  // set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 2'h0;
    end else begin
      irq_stat <= (irq_stat & ~(irq_clr_wr ? req.wdata[1:0] : 2'h0)) | chg;
    end
  end
  assign irq = |(irq_stat & irq_mask);

  logic color_flip; // an output with colour change enabled moved
  always_comb begin
    color_flip = 1'b0;
    for (int i = 0; i < N; i++) begin
      color_flip = color_flip | (chg[i] & cfg[i].color_chg);
    end
  end

  // colour flips only on backlight builds; starts green
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      backlight_red <= 1'b0;
    end else if (color_flip && backlit_ok) begin
      backlight_red <= ~backlight_red;
    end
  end

  color_flip_a: assert property (color_flip && backlit_ok
      |=> backlight_red != $past(backlight_red))
    else $error("backlight colour did not toggle");

  // ---------------- read path ----------------
  // data captured in the setup cycle, stable through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_setup) begin
      prdata <= 32'h0;
      case (req.addr)
        setpoint_pkg::OFF_SRC: prdata <= {26'h0, src_cfg};
        setpoint_pkg::OFF_STATUS: begin
          prdata <= {24'h0, backlight_red, card_ok, hold_q, pend_q, out_q};
        end
        setpoint_pkg::OFF_IRQ_STAT: prdata <= {30'h0, irq_stat};
        setpoint_pkg::OFF_IRQ_MASK: prdata <= {30'h0, irq_mask};
        default: begin
          for (int i = 0; i < N; i++) begin
            if (sp_hit(req.addr, i)) begin
              case (req.addr[4:0])
                setpoint_pkg::SPF_CFG: prdata <= {24'h0, cfg[i]};
                setpoint_pkg::SPF_THR: begin
                  prdata <= {{14{thr[i][17]}}, thr[i]};
                end
                setpoint_pkg::SPF_HYS: prdata <= {16'h0, hys[i]};
                setpoint_pkg::SPF_ON: prdata <= {16'h0, on_dly[i]};
                setpoint_pkg::SPF_OFF: prdata <= {16'h0, off_dly[i]};
                default: ;
              endcase
            end
          end
        end
      endcase
    end
  end

  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !mapped(paddr) |-> pslverr)
    else $error("unmapped access without error");
endmodule // setpoint_alarm_output_control

// >>> rtl/setpoint_pkg.sv
// package: register map, field layout, limits and timing for setpoint logic
// Operation
// - logic runs only with output card fitted
// - each setpoint has enable; disabled stays off
// - action: high/low acting, balanced/unbalanced hysteresis
// - signed threshold, at most 99999 display units
// - hysteresis programmable from 1 to 59999
// - unbalanced band below high, above low
// - on delay up to 5999 s; zero immediate
// - separate off delay up to 5999 s
// - auto reset; manual reset forces off, blocks
// - latch-immediate holds until manual/serial/power reset
// - latch-deferred reset waits for off trigger point
// - power up: outputs off, pending resets discarded
// - display reset resets output when input shown
// - standby holds output off until first crossing
// - output change toggles backlight colour if enabled
package setpoint_pkg;
  localparam int NSP = 2; // setpoints on the card
  localparam int VAL_W = 18; // signed display value width
  localparam int DLY_W = 16; // delay in tenths of a second
  localparam int unsigned CLK_HZ = 50_000_000; // pclk rate
  localparam int unsigned TICK_MS = 100; // delay resolution, 0.1 s
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic signed [VAL_W-1:0] THR_MAX = 18'h1869F; // 99999
  localparam logic signed [VAL_W-1:0] THR_MIN = 18'h3B1E1; // -19999
  localparam logic [15:0] HYS_MIN = 16'h0001; // 1 display unit
  localparam logic [15:0] HYS_MAX = 16'hEA5F; // 59999 units
  localparam logic [DLY_W-1:0] DLY_MAX = 16'hEA5F; // 5999.9 s
  // register byte offsets
  localparam logic [7:0] OFF_SRC = 8'h00; // reset source routing
  localparam logic [7:0] OFF_CMD = 8'h04; // serial reset command
  localparam logic [7:0] OFF_STATUS = 8'h08; // live state
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0C; // sticky events
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10; // event mask
  localparam logic [7:0] OFF_SP_BASE = 8'h20; // first setpoint block
  localparam logic [7:0] OFF_SP_END = 8'h60; // past last block
  localparam logic [4:0] SPF_CFG = 5'h00; // setpoint config
  localparam logic [4:0] SPF_THR = 5'h04; // threshold
  localparam logic [4:0] SPF_HYS = 5'h08; // hysteresis
  localparam logic [4:0] SPF_ON = 5'h0C; // on delay
  localparam logic [4:0] SPF_OFF = 5'h10; // off delay
  // source routing field positions
  localparam int SRC_BTN_MASK = 0; // [1:0] button resets setpoints
  localparam int SRC_BTN_DISP = 2; // button assigned to input display
  localparam int SRC_USR_MASK = 3; // [4:3] user input resets
  localparam int SRC_USR_DISP = 5; // user input assigned to display
  localparam logic [5:0] SRC_RST = 6'h00; // routing reset value
  localparam logic [7:0] CFG_RST = 8'h00; // setpoint config reset
  localparam logic [15:0] HYS_RST = 16'h0001; // hysteresis reset
  typedef enum logic [1:0] {
    ACT_HI_BAL, ACT_LO_BAL, ACT_HI_UNB, ACT_LO_UNB
  } action_e;
  typedef enum logic [1:0] {
    RST_AUTO, RST_LATCH_NOW, RST_LATCH_DEFERRED_CLEAR, RST_SPARE
  } reset_mode_e;
  // per setpoint configuration word, bit 0 is enable
  typedef struct packed {
    logic color_chg; // [7] backlight toggle on change
    logic disp_reset; // [6] reset with display reset
    logic standby; // [5] standby after power up
    reset_mode_e rmode; // [4:3] reset action
    action_e action; // [2:1] acting direction and band
    logic enable; // [0] setpoint enable
  } sp_cfg_s;
  // APB request as seen by the slave
  typedef struct packed {
    logic [7:0] addr;
    logic sel;
    logic enable;
    logic write;
    logic [31:0] wdata;
  } apb_req_s;
endpackage

// >>> testbench/output_card_model.sv
// behavioural model of the plug-in setpoint output card
module output_card_model (
  input wire logic pclk, // meter clock
  input wire logic present, // card seated in its slot
  input wire logic [1:0] sp_out, // drive from the meter
  output logic card_fitted // presence strap seen by the meter
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] relay = 2'h0; // relay contacts
  // strap is a plain level; a pulled card leaves the pin low
  assign card_fitted = present;
  // relays follow the drive only while seated, else drop out
  always_ff @(posedge pclk) relay <= present ? sp_out : 2'h0;
endmodule // output_card_model

// >>> testbench/setpoint_alarm_output_control_test.sv
// self-checking bench for the setpoint output controller
module setpoint_alarm_output_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0; // clock and power up reset
  logic [7:0] paddr = 8'h00; // apb address
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb controls
  logic [31:0] pwdata = 32'h0, prdata, rd; // apb data, last read
  logic pready, pslverr, irq, backlight_red, card_fitted, err, b;
  logic rst_button = 1'b0, user_input = 1'b0; // reset pins
  logic backlit_unit = 1'b1, present = 1'b1; // strap, card seated
  logic signed [17:0] display_value = 18'h0; // display reading
  logic display_valid = 1'b0, display_shown = 1'b1; // display flags
  logic [1:0] sp_out; // outputs to the card
  int num_errors = 0, cmp_count = 0, x; // counts, scratch
  always #10 pclk = ~pclk; // 50 MHz
  // tick shortened to 4 cycles so delays stay brief
  setpoint_alarm_output_control #(.TICK_CYCLES(4))
    setpoint_alarm_output_control_i (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .card_fitted(card_fitted),
    .rst_button(rst_button), .user_input(user_input),
    .backlit_unit(backlit_unit), .display_value(display_value),
    .display_valid(display_valid), .display_shown(display_shown),
    .sp_out(sp_out), .backlight_red(backlight_red), .irq(irq));
  output_card_model output_card_model_i (.pclk(pclk),
    .present(present), .sp_out(sp_out), .card_fitted(card_fitted));
  // counts, verdict, end of run
  task conclude;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 8) begin
      @(posedge pclk);
      n++;
    end
    if (n == 8) begin
      num_errors++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one display update, then room for the two-edge answer
  task show(input int v);
    @(posedge pclk);
    display_value <= 18'(v);
    display_valid <= 1'b1;
    @(posedge pclk);
    display_valid <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  function automatic logic [31:0] cfg(input int act, rm, col);
    setpoint_pkg::sp_cfg_s c;
    c = '0;
    c.enable = 1'b1;
    c.action = setpoint_pkg::action_e'(act);
    c.rmode = setpoint_pkg::reset_mode_e'(rm);
    c.color_chg = 1'(col);
    return {24'h0, c};
  endfunction
  // low acting codes have bit 0 set and turn on below the band
  function automatic logic want_on(input int act, input logic high);
    return act[0] ? !high : high;
  endfunction
  initial begin
    x = $urandom(32'hBC02);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(0, 8'h08, 0);
    chk(rd, 32'h70);
    apb(0, 8'h28, 0);
    chk(rd, 32'h1);
    apb(0, 8'hFC, 0);
    chk(err, 1); // unmapped place refused
    apb(1, 8'h24, 32'h30D40);
    apb(0, 8'h24, 0);
    chk(rd, 32'(setpoint_pkg::THR_MAX));
    apb(1, 8'h24, 0);
    apb(1, 8'h28, 32'hA);
    // every action, random readings well clear of the band
    for (int a = 0; a < 4; a++) begin
      apb(1, 8'h20, cfg(a, 0, 0));
      for (int k = 0; k < 6; k++) begin
        b = 1'($urandom_range(1, 0));
        x = 11 + $urandom_range(900, 0);
        show(b ? x : -x);
        chk(sp_out[0], want_on(a, b));
      end
    end
    apb(1, 8'h20, cfg(2, 0, 0));
    show(-20);
    show(0);
    chk(sp_out[0], 1);
    apb(1, 8'h20, cfg(0, 0, 1));
    show(-100);
    apb(1, 8'h10, 1);
    apb(1, 8'h0C, 3);
    b = backlight_red;
    show(100);
    chk(backlight_red, !b);
    chk(irq, 1); // irq follows unmasked change
    apb(1, 8'h0C, 1);
    @(posedge pclk);
    chk(irq, 0); // write one clears
    apb(1, 8'h00, 1);
    rst_button <= 1'b1;
    repeat (6) @(posedge pclk);
    rst_button <= 1'b0;
    chk(sp_out[0], 0);
    show(100);
    chk(sp_out[0], 0);
    show(-100);
    show(100);
    chk(sp_out[0], 1);
    apb(1, 8'h48, 32'hA);
    apb(1, 8'h40, cfg(0, 1, 0));
    show(100);
    show(-100);
    chk(sp_out[1], 1);
    apb(1, 8'h04, 2);
    repeat (2) @(posedge pclk);
    chk(sp_out[1], 0);
    apb(1, 8'h40, cfg(0, 2, 0));
    show(100);
    apb(1, 8'h04, 2);
    chk(sp_out[1], 1);
    show(-100);
    chk(sp_out[1], 0);
    apb(1, 8'h40, 0);
    show(100);
    chk(sp_out[1], 0);
    apb(1, 8'h20, cfg(0, 0, 0));
    show(-100);
    apb(1, 8'h2C, 2);
    show(100);
    chk(sp_out[0], 0);
    repeat (12) @(posedge pclk);
    chk(sp_out[0], 1);
    present <= 1'b0;
    repeat (5) @(posedge pclk);
    chk(sp_out, 0);
    conclude();
  end
endmodule // setpoint_alarm_output_control_test
